// ==== rtl/iasc_top.sv ====
// Address size checking and bypass for one translation context bank.
// Assumes an APB master on pclk; transactions are posted by register.
//
// Summary of operation
// R1 - Stage 1 bypass bank applies attribute-only stage
// R2 - Table walk accesses also get attribute stage
// R3 - Non-secure non-hypervisor banks always use VMID
// R4 - Override turns instruction accesses into data
// R5 - Secure fetch check runs after override
// R6 - Unprivileged cache maintenance control ignores enable
// R7 - Secure invalidate-all removes every secure entry
// R8 - Unrepresentable intermediate address raises size fault
// R9 - Output beyond downstream width raises size fault
// R10 - Top valid address bit selects table base
// R11 - Granules 4K, 16K, 64K; blocks also translate
// R12 - Intermediate and physical addresses capped 48 bits
// R13 - Upstream width field reports largest port
// R14 - No stage 1: upstream equals intermediate
// R15 - No stage 2: intermediate equals output
// R16 - Effective intermediate size depends on bank type
// R17 - Output limited by programmed physical size
// R18 - Early bypass truncates address to output width
// R19 - Others go to bank, sign-extended first
// R20 - Each stage checks input and output addresses
// R21 - Bypass on port disable, bypass type, unmatched
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
module iasc_top (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);
    import iasc_pkg::*;

    typedef struct packed {
        iasc_cfg_t   cfg;
        iasc_txn_t   txn;
        iasc_res_t   res;
        logic [3:0]  tlb_valid;
        logic [3:0]  tlb_sec;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } iasc_state_t;

    iasc_state_t state_reg;
    iasc_state_t state_next;

    // Identification values are derived so that a missing stage can
    // never report inconsistent widths.
    logic [2:0]  id_ias;
    logic [2:0]  id_oas;
    assign id_ias = IASC_S1_SUPP ? IASC_IAS_CODE : IASC_UBS_CODE; // R14
    assign id_oas = IASC_S2_SUPP ? IASC_OAS_CODE : id_ias;        // R15

    logic        setup;
    logic        wr_en;
    logic        go;
    logic        mapped;
    assign setup  = psel && !penable && !state_reg.pready;
    assign wr_en  = psel && penable && pwrite && state_reg.pready;
    assign go     = wr_en && paddr == IASC_TXN_OFF && pwdata[IASC_GO_BIT];
    assign mapped = paddr <= IASC_TLBSTAT_OFF && paddr[1:0] == 2'b00;

    // A command word carries its own attributes, so the evaluation must
    // see them in the cycle of the write, before they reach the register.
    iasc_txn_t   cur_txn;
    assign cur_txn = go ? {state_reg.txn.addr, pwdata[0], pwdata[1],
                           pwdata[2], pwdata[3], pwdata[4], pwdata[5]}
                        : state_reg.txn;

    // Evaluation of the posted transaction against the bank.
    iasc_res_t   eval;
    logic        byp;
    logic        unmatched;
    logic        s1_path;
    logic        sext;
    logic [63:0] va;
    logic [63:0] ipa;
    logic [63:0] pa;
    logic [6:0]  in_bits;
    logic [6:0]  eff_ias;
    logic [6:0]  pa_bits;
    logic [6:0]  lim;
    logic [6:0]  gshift;
    logic [63:0] out_mask;

    always_comb begin
        eval    = '0;
        va      = state_reg.txn.addr;
        ipa     = va;
        pa      = va;
        gshift  = 7'd12;
        in_bits = IASC_SHORT_IN;
        eff_ias = iasc_bits(id_ias);
        lim     = iasc_bits(id_oas);
        pa_bits = lim;
        sext    = 1'b0;
        eval.done = 1'b1;
        case (state_reg.cfg.ovr)
            IASC_OVR_DATA:  eval.instr = 1'b0; // R4
            IASC_OVR_INSTR: eval.instr = 1'b1;
            default:        eval.instr = cur_txn.instr;
        endcase
        unmatched = state_reg.cfg.nomatch || state_reg.cfg.multi;
        byp = state_reg.cfg.cpd || state_reg.cfg.str_byp
              || (!state_reg.cfg.usf && unmatched); // R21
        s1_path = state_reg.cfg.btype != IASC_S2_ONLY;
        out_mask = ~(64'hFFFF_FFFF_FFFF_FFFF << iasc_bits(id_oas));
        if (byp) begin
            eval.bypass = 1'b1;
            eval.out    = va & out_mask; // R18
        end else if (unmatched) begin
            eval.fault[IASC_F_UNMATCH] = 1'b1;
        end else begin
            // R19
            // The secure fetch check sees the overridden marking.
            eval.fault[IASC_F_SIF] = state_reg.cfg.secure_instr_fetch_check
                && cur_txn.secure && eval.instr
                && cur_txn.tgt_ns; // R5
            eval.fault[IASC_F_CMO] = cur_txn.cmo
                && cur_txn.unpriv && !state_reg.cfg.user_cache_maint_enable; // R6
            case (state_reg.cfg.gran)
                2'b00:   gshift = 7'd12;
                2'b01:   gshift = 7'd14;
                default: gshift = 7'd16;
            endcase
            eval.fault[IASC_F_GRAN] = state_reg.cfg.gran == 2'b11
                || !IASC_GRAN_SUPP[state_reg.cfg.gran]; // R11
            // Input check, with sign extension for long format in enabled non-hypervisor stage 1 banks.
            sext = s1_path && state_reg.cfg.long_sel && state_reg.cfg.en
                   && !state_reg.cfg.hyp;
            if (s1_path) begin
                in_bits = state_reg.cfg.long_sel ? IASC_UBS_BITS
                                                 : IASC_SHORT_IN; // R13
            end else begin
                in_bits = iasc_bits(id_ias);
            end
            if (sext) begin
                eval.ttbr1 = va[IASC_VA_TOP_BIT]; // R10
                eval.fault[IASC_F_INPUT] =
                    va[63:IASC_VA_TOP_BIT] != {16{va[IASC_VA_TOP_BIT]}};
                ipa = {16'h0000, va[47:0]};
            end else if (state_reg.cfg.en) begin
                eval.fault[IASC_F_INPUT] = (va >> in_bits) != 64'h0; // R20
            end
            // Block offsets are granule aligned, so larger blocks keep
            // every low bit of the input address.
            if (s1_path && state_reg.cfg.en && !cur_txn.walk) begin
                ipa = ipa + ({32'h0000_0000, state_reg.cfg.off1}
                             << gshift); // R11
            end
            eff_ias = (state_reg.cfg.btype == IASC_S1_BYP
                       && iasc_bits(id_oas) < iasc_bits(id_ias))
                      ? iasc_bits(id_oas) : iasc_bits(id_ias); // R16
            if (s1_path) begin
                eval.fault[IASC_F_IPA] = (ipa >> eff_ias) != 64'h0; // R8
            end
            pa = ipa;
            if (state_reg.cfg.btype != IASC_S1_BYP && state_reg.cfg.en) begin
                pa = ipa + ({32'h0000_0000, state_reg.cfg.off2} << gshift);
            end
            // R17
            if (state_reg.cfg.btype == IASC_S2_ONLY) begin
                lim = iasc_bits(state_reg.cfg.pa_s2);
            end else if (state_reg.cfg.btype == IASC_S1_S2
                         && state_reg.cfg.pa_s2 < state_reg.cfg.pa_s1) begin
                lim = iasc_bits(state_reg.cfg.pa_s2);
            end else begin
                lim = iasc_bits(state_reg.cfg.pa_s1);
            end
            pa_bits = lim < iasc_bits(id_oas) ? lim : iasc_bits(id_oas);
            eval.fault[IASC_F_PA] = (pa >> pa_bits) != 64'h0; // R9 R12
            // Stage 1 bypass still runs the attribute-only stage.
            eval.attr = state_reg.cfg.btype == IASC_S1_BYP
                        ? state_reg.cfg.attr1 : state_reg.cfg.attr2; // R1 R2
            eval.vmid = (!state_reg.cfg.sec && !state_reg.cfg.hyp)
                        ? state_reg.cfg.vmid : 8'h00; // R3
            eval.out = eval.fault == 7'h00 ? pa : 64'h0;
        end
    end

    // Register file, TLB tags and APB answer.
    always_comb begin
        state_next = state_reg;
        state_next.pready  = setup;
        state_next.pslverr = setup && !mapped;
        if (setup) begin
            case (paddr)
                IASC_CTRL_OFF:    state_next.prdata = {29'h0,
                    state_reg.cfg.secure_instr_fetch_check, state_reg.cfg.usf, state_reg.cfg.cpd};
                IASC_STREAM_OFF:  state_next.prdata = {26'h0,
                    state_reg.cfg.ovr, 1'b0, state_reg.cfg.multi,
                    state_reg.cfg.nomatch, state_reg.cfg.str_byp};
                IASC_BANK_OFF:    state_next.prdata = {state_reg.cfg.attr1,
                    5'h00, state_reg.cfg.pa_s2, 1'b0, state_reg.cfg.pa_s1,
                    2'b00, state_reg.cfg.gran, 1'b0, state_reg.cfg.user_cache_maint_enable,
                    state_reg.cfg.sec, state_reg.cfg.hyp,
                    state_reg.cfg.long_sel, state_reg.cfg.en,
                    state_reg.cfg.btype};
                IASC_VMID_OFF:    state_next.prdata = {8'h00,
                    state_reg.cfg.attr2, 8'h00, state_reg.cfg.vmid};
                IASC_OFFS1_OFF:   state_next.prdata = state_reg.cfg.off1;
                IASC_OFFS2_OFF:   state_next.prdata = state_reg.cfg.off2;
                IASC_ADDR_LO_OFF: state_next.prdata = state_reg.txn.addr[31:0];
                IASC_ADDR_HI_OFF: state_next.prdata = state_reg.txn.addr[63:32];
                IASC_TXN_OFF:     state_next.prdata = {26'h0,
                    state_reg.txn.tgt_ns, state_reg.txn.walk,
                    state_reg.txn.unpriv, state_reg.txn.cmo,
                    state_reg.txn.secure, state_reg.txn.instr};
                IASC_STATUS_OFF:  state_next.prdata = {21'h0,
                    state_reg.res.ttbr1, state_reg.res.instr,
                    state_reg.res.bypass, state_reg.res.fault,
                    state_reg.res.done};
                IASC_OUT_LO_OFF:  state_next.prdata = state_reg.res.out[31:0];
                IASC_OUT_HI_OFF:  state_next.prdata = state_reg.res.out[63:32];
                IASC_RESULT_OFF:  state_next.prdata = {16'h0,
                    state_reg.res.attr, state_reg.res.vmid};
                IASC_ID0_OFF:     state_next.prdata = {30'h0,
                    IASC_S2_SUPP, IASC_S1_SUPP};
                IASC_ID2_OFF:     state_next.prdata = {20'h0, 1'b0,
                    id_oas, 1'b0, id_ias, 1'b0, IASC_UBS_CODE}; // R13
                IASC_TLBSTAT_OFF: state_next.prdata = {24'h0,
                    state_reg.tlb_sec, state_reg.tlb_valid};
                default:          state_next.prdata = IASC_ZERO_RST;
            endcase
        end
        if (wr_en) begin
            case (paddr)
                IASC_CTRL_OFF: begin
                    state_next.cfg.cpd = pwdata[0];
                    state_next.cfg.usf = pwdata[1];
                    state_next.cfg.secure_instr_fetch_check = pwdata[2];
                end
                IASC_STREAM_OFF: begin
                    state_next.cfg.str_byp = pwdata[0];
                    state_next.cfg.nomatch = pwdata[1];
                    state_next.cfg.multi   = pwdata[2];
                    state_next.cfg.ovr     = iasc_ovr_t'(pwdata[5:4]);
                end
                IASC_BANK_OFF: begin
                    state_next.cfg.btype    = iasc_bank_type_t'(pwdata[1:0]);
                    state_next.cfg.en       = pwdata[2];
                    state_next.cfg.long_sel = pwdata[3];
                    state_next.cfg.hyp      = pwdata[4];
                    state_next.cfg.sec      = pwdata[5];
                    state_next.cfg.user_cache_maint_enable      = pwdata[6];
                    state_next.cfg.gran     = pwdata[9:8];
                    state_next.cfg.pa_s1    = pwdata[14:12];
                    state_next.cfg.pa_s2    = pwdata[18:16];
                    state_next.cfg.attr1    = pwdata[31:24];
                end
                IASC_VMID_OFF: begin
                    state_next.cfg.vmid  = pwdata[7:0];
                    state_next.cfg.attr2 = pwdata[23:16];
                end
                IASC_OFFS1_OFF:   state_next.cfg.off1 = pwdata;
                IASC_OFFS2_OFF:   state_next.cfg.off2 = pwdata;
                IASC_ADDR_LO_OFF: state_next.txn.addr[31:0]  = pwdata;
                IASC_ADDR_HI_OFF: state_next.txn.addr[63:32] = pwdata;
                IASC_TXN_OFF: begin
                    state_next.txn.instr  = pwdata[0];
                    state_next.txn.secure = pwdata[1];
                    state_next.txn.cmo    = pwdata[2];
                    state_next.txn.unpriv = pwdata[3];
                    state_next.txn.walk   = pwdata[4];
                    state_next.txn.tgt_ns = pwdata[5];
                end
                IASC_TLBCMD_OFF: begin
                    // Secure hypervisor entries are removed as well.
                    if (pwdata[0]) begin
                        state_next.tlb_valid = state_reg.tlb_valid
                                               & ~state_reg.tlb_sec; // R7
                    end
                end
                default: begin
                end
            endcase
        end
        // The evaluation reads the bank and address registers as they stood before
        // this write, and takes the attributes straight from the command word.
        if (go) begin
            state_next.res = eval;
            if (!eval.bypass && eval.fault == 7'h00) begin
                state_next.tlb_valid[va[IASC_TLB_IDX_LO +: 2]] = 1'b1;
                state_next.tlb_sec[va[IASC_TLB_IDX_LO +: 2]] =
                    state_reg.cfg.sec;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg           <= '0;
            state_reg.cfg.pa_s1 <= IASC_PA_RST;
            state_reg.cfg.pa_s2 <= IASC_PA_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    assign prdata  = state_reg.prdata;
    assign pready  = state_reg.pready;
    assign pslverr = state_reg.pslverr;

    // Checks on the design's own behaviour.
    logic [63:0] oas_mask_chk;
    assign oas_mask_chk = ~(64'hFFFF_FFFF_FFFF_FFFF << iasc_bits(id_oas));

    a_bypass_trunc: assert property ( // R18
        @(posedge pclk) disable iff (!presetn)
        state_reg.res.bypass |-> (state_reg.res.out & ~oas_mask_chk) == 0)
        else $error("bypass output exceeds output width");
    a_bypass_cause: assert property ( // R21
        @(posedge pclk) disable iff (!presetn)
        go && state_reg.cfg.cpd |=> state_reg.res.bypass)
        else $error("port disable did not bypass");
    a_instr_override: assert property ( // R4 R5
        @(posedge pclk) disable iff (!presetn)
        go && state_reg.cfg.ovr == IASC_OVR_DATA
        |=> !state_reg.res.instr && !state_reg.res.fault[IASC_F_SIF])
        else $error("overridden access kept instruction marking");
    a_cmo_any_en: assert property ( // R6
        @(posedge pclk) disable iff (!presetn)
        go && !byp && !unmatched && cur_txn.cmo
        && cur_txn.unpriv && !state_reg.cfg.user_cache_maint_enable
        |=> state_reg.res.fault[IASC_F_CMO])
        else $error("unprivileged maintenance not refused");
    a_pa_limit: assert property ( // R9 R17
        @(posedge pclk) disable iff (!presetn)
        state_reg.res.done && !state_reg.res.bypass
        && state_reg.res.fault == 7'h00
        |-> (state_reg.res.out & ~oas_mask_chk) == 0)
        else $error("output address above downstream width");
    a_vmid_used: assert property ( // R3
        @(posedge pclk) disable iff (!presetn)
        go && !byp && !unmatched && !state_reg.cfg.sec && !state_reg.cfg.hyp
        |=> state_reg.res.vmid == $past(state_reg.cfg.vmid))
        else $error("non-secure bank lost its VMID");
    a_sec_inval: assert property ( // R7
        @(posedge pclk) disable iff (!presetn)
        wr_en && paddr == IASC_TLBCMD_OFF && pwdata[0]
        |=> (state_reg.tlb_valid & state_reg.tlb_sec) == 4'h0)
        else $error("secure entry survived invalidate");
    a_attr_stage: assert property ( // R1 R2
        @(posedge pclk) disable iff (!presetn)
        go && !byp && !unmatched && state_reg.cfg.btype == IASC_S1_BYP
        |=> state_reg.res.attr == $past(state_reg.cfg.attr1))
        else $error("attribute-only stage not applied");
    a_id_match: assert property ( // R14 R15
        @(posedge pclk) disable iff (!presetn)
        (IASC_S1_SUPP || id_ias == IASC_UBS_CODE)
        && (IASC_S2_SUPP || id_oas == id_ias))
        else $error("identification widths inconsistent");
    a_apb_answer: assert property (
        @(posedge pclk) disable iff (!presetn)
        setup |=> pready ##1 !pready)
        else $error("APB answer not one cycle after setup");
    // The effective size of a bypassed stage 1 never exceeds the port.
    a_ipa_effective: assert property ( // R8 R16
        @(posedge pclk) disable iff (!presetn)
        go && !byp && !unmatched && state_reg.cfg.btype == IASC_S1_BYP
        && (ipa >> iasc_bits(id_oas)) != 64'h0
        |=> state_reg.res.fault[IASC_F_IPA])
        else $error("intermediate address above effective size");
    a_table_select: assert property ( // R10
        @(posedge pclk) disable iff (!presetn)
        go && !byp && !unmatched && sext
        |=> state_reg.res.ttbr1 == $past(va[IASC_VA_TOP_BIT]))
        else $error("top address bit did not pick the table base");

    c_bypass: cover property (@(posedge pclk) go && byp);
    c_ipa_fault: cover property (@(posedge pclk)
        state_reg.res.fault[IASC_F_IPA]);
    c_sign_ext: cover property (@(posedge pclk) go && sext);
    c_inval: cover property (@(posedge pclk)
        wr_en && paddr == IASC_TLBCMD_OFF);

endmodule : iasc_top

// ==== rtl/iasc_pkg.sv ====
// Package for the address size checking block: register map, field
// layouts, reset values, size encodings and the packed carriers.
// Assumes a single 100 MHz clock domain and an APB register bus.
package iasc_pkg;

    // Register byte offsets.
    localparam logic [7:0] IASC_CTRL_OFF     = 8'h00;
    localparam logic [7:0] IASC_STREAM_OFF   = 8'h04;
    localparam logic [7:0] IASC_BANK_OFF     = 8'h08;
    localparam logic [7:0] IASC_VMID_OFF     = 8'h0C;
    localparam logic [7:0] IASC_OFFS1_OFF    = 8'h10;
    localparam logic [7:0] IASC_OFFS2_OFF    = 8'h14;
    localparam logic [7:0] IASC_ADDR_LO_OFF  = 8'h18;
    localparam logic [7:0] IASC_ADDR_HI_OFF  = 8'h1C;
    localparam logic [7:0] IASC_TXN_OFF      = 8'h20;
    localparam logic [7:0] IASC_STATUS_OFF   = 8'h24;
    localparam logic [7:0] IASC_OUT_LO_OFF   = 8'h28;
    localparam logic [7:0] IASC_OUT_HI_OFF   = 8'h2C;
    localparam logic [7:0] IASC_RESULT_OFF   = 8'h30;
    localparam logic [7:0] IASC_TLBCMD_OFF   = 8'h34;
    localparam logic [7:0] IASC_ID0_OFF      = 8'h38;
    localparam logic [7:0] IASC_ID2_OFF      = 8'h3C;
    localparam logic [7:0] IASC_TLBSTAT_OFF  = 8'h40;

    // Field positions.
    localparam int IASC_GO_BIT     = 31;
    localparam int IASC_VA_TOP_BIT = 48;
    localparam int IASC_TLB_IDX_LO = 12;

    // Identification: size codes 0..5 mean 32,36,40,42,44,48 bits.
    localparam logic [2:0] IASC_UBS_CODE  = 3'h5;
    localparam logic [2:0] IASC_IAS_CODE  = 3'h5;
    localparam logic [2:0] IASC_OAS_CODE  = 3'h4;
    localparam logic       IASC_S1_SUPP   = 1'b1;
    localparam logic       IASC_S2_SUPP   = 1'b1;
    localparam logic [2:0] IASC_GRAN_SUPP = 3'h7;
    localparam logic [6:0] IASC_UBS_BITS  = 7'd49;
    localparam logic [6:0] IASC_SHORT_IN  = 7'd32;
    localparam logic [6:0] IASC_MAX_BITS  = 7'd48;

    // Reset values.
    localparam logic [31:0] IASC_ZERO_RST = 32'h0000_0000;
    localparam logic [2:0]  IASC_PA_RST   = 3'h5;

    typedef enum logic [1:0] {
        IASC_S1_S2  = 2'b00,
        IASC_S1_BYP = 2'b01,
        IASC_S2_ONLY = 2'b10,
        IASC_TYPE_RSV = 2'b11
    } iasc_bank_type_t;

    typedef enum logic [1:0] {
        IASC_OVR_KEEP  = 2'b00,
        IASC_OVR_RSV   = 2'b01,
        IASC_OVR_DATA  = 2'b10,
        IASC_OVR_INSTR = 2'b11
    } iasc_ovr_t;

    // Fault bit positions in the fault field, status word bits 7:1.
    localparam int IASC_F_UNMATCH = 0;
    localparam int IASC_F_CMO     = 1;
    localparam int IASC_F_SIF     = 2;
    localparam int IASC_F_INPUT   = 3;
    localparam int IASC_F_IPA     = 4;
    localparam int IASC_F_PA      = 5;
    localparam int IASC_F_GRAN    = 6;

    typedef struct packed {
        logic            cpd;
        logic            usf;
        logic            secure_instr_fetch_check;
        logic            str_byp;
        logic            nomatch;
        logic            multi;
        iasc_ovr_t       ovr;
        iasc_bank_type_t btype;
        logic            en;
        logic            long_sel;
        logic            hyp;
        logic            sec;
        logic            user_cache_maint_enable;
        logic [1:0]      gran;
        logic [2:0]      pa_s1;
        logic [2:0]      pa_s2;
        logic [7:0]      attr1;
        logic [7:0]      vmid;
        logic [7:0]      attr2;
        logic [31:0]     off1;
        logic [31:0]     off2;
    } iasc_cfg_t;

    typedef struct packed {
        logic [63:0] addr;
        logic        instr;
        logic        secure;
        logic        cmo;
        logic        unpriv;
        logic        walk;
        logic        tgt_ns;
    } iasc_txn_t;

    typedef struct packed {
        logic        done;
        logic [6:0]  fault;
        logic        bypass;
        logic        instr;
        logic        ttbr1;
        logic [7:0]  attr;
        logic [7:0]  vmid;
        logic [63:0] out;
    } iasc_res_t;

    // Size code to bit count, never above the 48-bit ceiling.
    function automatic logic [6:0] iasc_bits(input logic [2:0] code);
        case (code)
            3'h0:    iasc_bits = 7'd32;
            3'h1:    iasc_bits = 7'd36;
            3'h2:    iasc_bits = 7'd40;
            3'h3:    iasc_bits = 7'd42;
            3'h4:    iasc_bits = 7'd44;
            default: iasc_bits = IASC_MAX_BITS;
        endcase
    endfunction : iasc_bits

endpackage : iasc_pkg

// ==== verification/iasc_apb_bfm.sv ====
// APB requester standing in for software on the register bus.
// Assumes pready answers every access; the bench bounds the waits.
`timescale 1ns/10ps
module iasc_apb_bfm (
    input  wire logic        pclk,
    output logic             psel = 1'b0,
    output logic             penable = 1'b0,
    output logic             pwrite = 1'b0,
    output logic [7:0]       paddr = 8'h00,
    output logic [31:0]      pwdata = 32'h0000_0000,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    // The request stands until pready is seen high at a rising edge.
    task automatic xfer(logic w, logic [7:0] a, logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : iasc_apb_bfm

// ==== verification/tb_top.sv ====
// Self-checking bench for the address size checking block.
// Assumes iasc_pkg, iasc_top and iasc_apb_bfm are compiled first.
`timescale 1ns/10ps
module tb_top;
    import iasc_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr, e;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q, s;
    logic [63:0] a;
    int          fails = 0, checked = 0, cyc = 0;
    logic [1:0]  ov[3] = '{2'h0, 2'h2, 2'h3};
    logic [8:0]  rows[5] = '{9'h021, 9'h003, 9'h005, 9'h009, 9'h044};
    always #5 pclk = ~pclk;
    iasc_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr);
    iasc_apb_bfm u_bfm (.pclk, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr);
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Bypassed addresses keep only the 44 bits of the downstream port.
    function automatic logic [63:0] trunc_exp(input logic [63:0] ad);
        return ad & 64'h0000_0FFF_FFFF_FFFF;
    endfunction : trunc_exp
    task automatic bus(logic w, logic [7:0] ad, logic [31:0] d = 32'h0);
        u_bfm.xfer(w, ad, d, q, e);
    endtask : bus
    task automatic txn(input logic [63:0] ad, input logic [5:0] f);
        bus(1'b1, IASC_ADDR_LO_OFF, ad[31:0]);
        bus(1'b1, IASC_ADDR_HI_OFF, ad[63:32]);
        bus(1'b1, IASC_TXN_OFF, {1'b1, 25'h000_0000, f});
        bus(1'b0, IASC_STATUS_OFF);
    endtask : txn
    task automatic print_verdict();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict
    always @(posedge pclk)
        if (++cyc == 20000) begin
            fails++;
            print_verdict();
        end
    initial begin
        void'($urandom(32'h88d3fdf6));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        bus(1'b0, 8'h44);
        chk({e, q}, 33'h1_0000_0000);
        // Rows hold control, stream and expected bypass.
        foreach (rows[i]) begin
            bus(1'b1, IASC_CTRL_OFF, {28'h000_0000, rows[i][8:5]});
            bus(1'b1, IASC_STREAM_OFF, {28'h000_0000, rows[i][4:1]});
            a = {$urandom, $urandom};
            txn(a, 6'h00);
            chk({q[8], q[1]}, {rows[i][0], ~rows[i][0]});
            bus(1'b0, IASC_OUT_LO_OFF);
            s = q;
            bus(1'b0, IASC_OUT_HI_OFF);
            chk({q, s}, rows[i][0] ? trunc_exp(a) : 64'h0);
        end
        bus(1'b1, IASC_CTRL_OFF, 32'h0000_0000);
        bus(1'b1, IASC_STREAM_OFF, 32'h0000_0000);
        s = $urandom;
        bus(1'b1, IASC_BANK_OFF, {s[31:24], 24'h05_500D});
        bus(1'b1, IASC_VMID_OFF, {8'h00, s[23:16], 8'h00, s[7:0]});
        for (int w = 0; w < 2; w++) begin
            txn({40'h00_0000_0000, s[23:12], 12'h000}, {1'b0, w[0], 4'h0});
            chk(q[7:1], 7'h00);
            bus(1'b0, IASC_RESULT_OFF);
            chk(q[15:0], {s[31:24], s[7:0]});
        end
        txn(64'h0000_1000_0000_0000, 6'h00);
        chk(q[7:1], 7'h30);
        txn(64'hFFFF_0000_0000_1000, 6'h00);
        chk(q[10:1], 10'h200);
        txn(64'h0002_0000_0000_1000, 6'h00);
        chk(q[7:1], 7'h08);
        $display("test bypass and stage done");
        bus(1'b1, IASC_CTRL_OFF, 32'h0000_0004);
        for (int k = 0; k < 6; k++) begin
            bus(1'b1, IASC_STREAM_OFF, {26'h000_0000, ov[k/2], 4'h0});
            txn(64'h0000_0000_0000_2000, {5'h11, k[0]});
            chk({q[9], q[3]}, {2{ov[k/2][1] ? ov[k/2][0] : k[0]}});
        end
        bus(1'b1, IASC_CTRL_OFF, 32'h0000_0000);
        bus(1'b1, IASC_BANK_OFF, 32'h0005_502D);
        txn(64'h0000_0000_0000_1000, 6'h02);
        bus(1'b1, IASC_TLBCMD_OFF, 32'h0000_0001);
        bus(1'b0, IASC_TLBSTAT_OFF);
        chk({q[5], q[2], q[1]}, 3'h6);
        bus(1'b1, IASC_BANK_OFF, 32'h0005_5029);
        txn(64'h0000_0000_0000_1000, 6'h0C);
        chk(q[7:1], 7'h02);
        bus(1'b1, IASC_BANK_OFF, 32'h0000_5006);
        txn(64'h0000_0001_0000_1000, 6'h00);
        chk(q[7:1], 7'h20);
        bus(1'b1, IASC_BANK_OFF, 32'h0005_0004);
        txn(64'h0000_0001_0000_1000, 6'h00);
        chk(q[7:1], 7'h28);
        $display("test override and tlb done");
        print_verdict();
    end
endmodule : tb_top
